// >>> hw/bus_ctrl_defs.vh
// Purpose: Shared constants for the backplane bus controller
// Assumes: Included by bare name from the design files
// Notes: Timing counts are in cycles of the 250 MHz core clock
`ifndef BUS_CTRL_DEFS_VH
`define BUS_CTRL_DEFS_VH
// ------------------------------------------------------------
// Cycle kinds on the command port
// ------------------------------------------------------------
`define KIND_MEM_RD 2'h0
`define KIND_MEM_WR 2'h1
`define KIND_IO_RD 2'h2
`define KIND_IO_WR 2'h3
// ------------------------------------------------------------
// Machine cycle states
// ------------------------------------------------------------
`define ST_IDLE 3'h0
`define ST_ADDR 3'h1
`define ST_XFER 3'h2
`define ST_DONE 3'h3
`define ST_RELEASED 3'h4
`define ST_INTAK 3'h5
`define ST_REFRESH 3'h6
// ------------------------------------------------------------
// Timing and reset values
// ------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define SYNC_SYS_CLOCK_NS 125
`define POR_TIME_NS 1000
`define POR_CYCLES ((`POR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POR_CNT_W 9
`define REFRESH_INTERVAL 16'h0200
`define ADDR_RESET 16'h0000
`define DATA_RESET 8'h00
`endif

// >>> hw/sync2.v
// Purpose: Two flip-flop synchroniser for a vector of pins
// Assumes: Inputs are asynchronous to clk_i
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
module sync2 #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Data
   input wire [WIDTH-1:0] d_i,
   output wire [WIDTH-1:0] q_o
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] stable_reg;
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         meta_reg <= INIT;
         stable_reg <= INIT;
      end else begin
         meta_reg <= d_i;
         stable_reg <= meta_reg;
      end
   end
   assign q_o = stable_reg;
endmodule // sync2

// >>> hw/reset_gen.v
// Purpose: System reset generator from power-on and pushbutton
// Assumes: Pushbutton input already synchronised
// Notes: Power-on stretch counted from the core reset release
`timescale 1ns/1ps
`include "bus_ctrl_defs.vh"
module reset_gen #(
   parameter POR_COUNT = `POR_CYCLES
) (
   // Clock and reset
   input wire clk_i,
   input wire rst_n_i,
   // Reset sources and output
   input wire pb_reset_n_i,
   output reg sys_reset_n_o
);
   reg [`POR_CNT_W-1:0] por_cnt_reg;
   wire por_done;
   assign por_done = (por_cnt_reg == POR_COUNT[`POR_CNT_W-1:0]);
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         por_cnt_reg <= {`POR_CNT_W{1'b0}};
         sys_reset_n_o <= 1'b0;
      end else begin
         if (!por_done) begin
            por_cnt_reg <= por_cnt_reg + 1'b1;
         end
         sys_reset_n_o <= por_done & pb_reset_n_i;
      end
   end
endmodule // reset_gen

// >>> hw/bus_ctrl.v
// Purpose: Processor-side controller of an 8-bit backplane bus
// Assumes: All bus pins asynchronous; bus clock sampled, not used as clock
// Notes: Machine cycles advance on rising edges of the bus clock
//
// What this block does
// - Float data drivers unless transferring
// - Data lines are active high
// - Strobes set data direction
// - Drive tri-state active-high address bus
// - Float bus on request after cycle
// - Assert bus acknowledge at cycle end
// - I/O request only with valid I/O address
// - Memory request only with valid address
// - Write strobe only with valid data
// - Generate tri-state refresh strobe
// - One sync pulse per machine cycle
// - Status one marks instruction fetch
// - Ignore masked interrupt requests
// - Acknowledge accepted interrupt with INTAK
// - Wait request stalls, address held
// - Non-maskable interrupt has top priority after bus request
// - Reset on power-on or pushbutton
`timescale 1ns/1ps
`include "bus_ctrl_defs.vh"
module bus_ctrl #(
   parameter POR_COUNT = `POR_CYCLES,
   parameter [15:0] REFRESH_GAP = `REFRESH_INTERVAL
) (
   // Clock and reset
   input wire CLOCK_I,
   input wire RST_N_I,
   // Core command port
   input wire CMD_VALID_I,
   input wire [1:0] CMD_KIND_I,
   input wire CMD_FETCH_I,
   input wire [15:0] CMD_ADDR_I,
   input wire [7:0] CMD_WDATA_I,
   input wire INT_ENABLE_I,
   output reg CMD_READY_O,
   output reg RSP_VALID_O,
   output reg [7:0] RSP_RDATA_O,
   output reg NMI_TAKEN_O,
   output reg INT_TAKEN_O,
   output reg [7:0] INT_VECTOR_O,
   // Bus clock sampled from the backplane
   input wire BUS_CLOCK_N_I,
   // Address bus
   output reg [15:0] ADDR_O,
   output reg ADDR_OE_O,
   // Data bus
   input wire [7:0] DATA_I,
   output reg [7:0] DATA_O,
   output reg DATA_OE_O,
   // Control strobes
   output reg RD_N_O,
   output reg WR_N_O,
   output reg MEMRQ_N_O,
   output reg IORQ_N_O,
   output reg REFRESH_N_O,
   output reg MCSYNC_N_O,
   output reg STATUS1_N_O,
   output reg CTRL_OE_O,
   output reg INTAK_N_O,
   // Bus handover, wait, interrupts
   input wire BUSRQ_N_I,
   output reg BUSAK_N_O,
   input wire WAITRQ_N_I,
   input wire INTRQ_N_I,
   input wire NMIRQ_N_I,
   // System reset
   input wire PBRESET_N_I,
   output reg SYSRESET_N_O
);
   // ------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------
   wire [7:0] data_s;
   wire [5:0] ctl_s;
   wire clk_s, busrq_n_s, waitrq_n_s, intrq_n_s, nmirq_n_s, pbreset_n_s;
   sync2 #(.WIDTH(8), .INIT(8'h00)) u_data_sync (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .d_i(DATA_I),
      .q_o(data_s)
   );
   sync2 #(.WIDTH(6), .INIT(6'h3f)) u_ctl_sync (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .d_i({BUS_CLOCK_N_I, BUSRQ_N_I, WAITRQ_N_I, INTRQ_N_I, NMIRQ_N_I, PBRESET_N_I}),
      .q_o(ctl_s)
   );
   assign {clk_s, busrq_n_s, waitrq_n_s, intrq_n_s, nmirq_n_s, pbreset_n_s} = ctl_s;
   // ------------------------------------------------------------
   // Bus clock edge and system reset
   // ------------------------------------------------------------
   reg clk_d_reg;
   wire tick;
   wire sys_reset_n;
   // Active-low bus clock: its falling level edge is the processor rising edge
   assign tick = clk_d_reg & ~clk_s;
   reset_gen #(.POR_COUNT(POR_COUNT)) u_reset_gen (
      .clk_i(CLOCK_I),
      .rst_n_i(RST_N_I),
      .pb_reset_n_i(pbreset_n_s),
      .sys_reset_n_o(sys_reset_n)
   );
   // ------------------------------------------------------------
   // Machine cycle sequencer
   // ------------------------------------------------------------
   reg [2:0] state_reg;
   reg [1:0] kind_reg;
   reg fetch_reg;
   reg nmi_pend_reg;
   reg nmi_prev_reg;
   reg [15:0] ref_cnt_reg;
   reg [6:0] ref_addr_reg;
   wire is_rd;
   wire is_io;
   wire ref_due;
   wire nmi_edge;
   // Edge seen this cycle counts too, so a tick on the same edge cannot favour INTRQ
   assign nmi_edge = nmi_prev_reg & ~nmirq_n_s;
   assign is_rd = (kind_reg == `KIND_MEM_RD) || (kind_reg == `KIND_IO_RD);
   assign is_io = kind_reg[1];
   assign ref_due = (ref_cnt_reg == REFRESH_GAP);
   always @(posedge CLOCK_I) begin
      if (!RST_N_I) begin
         clk_d_reg <= 1'b1;
         state_reg <= `ST_IDLE;
         kind_reg <= `KIND_MEM_RD;
         fetch_reg <= 1'b0;
         nmi_pend_reg <= 1'b0;
         nmi_prev_reg <= 1'b1;
         ref_cnt_reg <= 16'h0000;
         ref_addr_reg <= 7'h00;
         ADDR_O <= `ADDR_RESET;
         ADDR_OE_O <= 1'b0;
         DATA_O <= `DATA_RESET;
         DATA_OE_O <= 1'b0;
         RD_N_O <= 1'b1;
         WR_N_O <= 1'b1;
         MEMRQ_N_O <= 1'b1;
         IORQ_N_O <= 1'b1;
         REFRESH_N_O <= 1'b1;
         MCSYNC_N_O <= 1'b1;
         STATUS1_N_O <= 1'b1;
         CTRL_OE_O <= 1'b0;
         INTAK_N_O <= 1'b1;
         BUSAK_N_O <= 1'b1;
         CMD_READY_O <= 1'b0;
         RSP_VALID_O <= 1'b0;
         RSP_RDATA_O <= `DATA_RESET;
         NMI_TAKEN_O <= 1'b0;
         INT_TAKEN_O <= 1'b0;
         INT_VECTOR_O <= `DATA_RESET;
         SYSRESET_N_O <= 1'b0;
      end else begin
         clk_d_reg <= clk_s;
         SYSRESET_N_O <= sys_reset_n;
         RSP_VALID_O <= 1'b0;
         NMI_TAKEN_O <= 1'b0;
         INT_TAKEN_O <= 1'b0;
         CMD_READY_O <= 1'b0;
         nmi_prev_reg <= nmirq_n_s;
         // Edge-latched so a short pulse is not lost; set wins over take
         if (nmi_edge) begin
            nmi_pend_reg <= 1'b1;
         end else if (NMI_TAKEN_O) begin
            nmi_pend_reg <= 1'b0;
         end
         if (!ref_due) begin
            ref_cnt_reg <= ref_cnt_reg + 16'h0001;
         end
         if (!sys_reset_n) begin
            state_reg <= `ST_IDLE;
            ADDR_OE_O <= 1'b0;
            DATA_OE_O <= 1'b0;
            CTRL_OE_O <= 1'b0;
            BUSAK_N_O <= 1'b1;
            RD_N_O <= 1'b1;
            WR_N_O <= 1'b1;
            MEMRQ_N_O <= 1'b1;
            IORQ_N_O <= 1'b1;
            REFRESH_N_O <= 1'b1;
            MCSYNC_N_O <= 1'b1;
            STATUS1_N_O <= 1'b1;
            INTAK_N_O <= 1'b1;
            nmi_pend_reg <= 1'b0;
         end else if (tick) begin
            case (state_reg)
               `ST_IDLE: begin
                  MCSYNC_N_O <= 1'b1;
                  CTRL_OE_O <= 1'b1;
                  ADDR_OE_O <= 1'b1;
                  if (!busrq_n_s) begin
                     ADDR_OE_O <= 1'b0;
                     DATA_OE_O <= 1'b0;
                     CTRL_OE_O <= 1'b0;
                     BUSAK_N_O <= 1'b0;
                     state_reg <= `ST_RELEASED;
                  end else if (nmi_pend_reg || nmi_edge) begin
                     NMI_TAKEN_O <= 1'b1;
                  end else if (!intrq_n_s && INT_ENABLE_I) begin
                     MCSYNC_N_O <= 1'b0;
                     INTAK_N_O <= 1'b0;
                     state_reg <= `ST_INTAK;
                  end else if (ref_due) begin
                     ADDR_O <= {9'h000, ref_addr_reg};
                     REFRESH_N_O <= 1'b0;
                     MEMRQ_N_O <= 1'b0;
                     MCSYNC_N_O <= 1'b0;
                     ref_addr_reg <= ref_addr_reg + 7'h01;
                     ref_cnt_reg <= 16'h0000;
                     state_reg <= `ST_REFRESH;
                  end else if (CMD_VALID_I) begin
                     kind_reg <= CMD_KIND_I;
                     fetch_reg <= CMD_FETCH_I;
                     ADDR_O <= CMD_ADDR_I;
                     DATA_O <= CMD_WDATA_I;
                     MCSYNC_N_O <= 1'b0;
                     STATUS1_N_O <= ~(CMD_FETCH_I && CMD_KIND_I == `KIND_MEM_RD);
                     CMD_READY_O <= 1'b1;
                     state_reg <= `ST_ADDR;
                  end
               end
               `ST_ADDR: begin
                  MCSYNC_N_O <= 1'b1;
                  MEMRQ_N_O <= is_io;
                  IORQ_N_O <= ~is_io;
                  RD_N_O <= ~is_rd;
                  DATA_OE_O <= ~is_rd;
                  state_reg <= `ST_XFER;
               end
               `ST_XFER: begin
                  // Wait holds strobes and address
                  if (waitrq_n_s) begin
                     WR_N_O <= is_rd;
                     state_reg <= `ST_DONE;
                  end
               end
               `ST_DONE: begin
                  if (is_rd) begin
                     RSP_RDATA_O <= data_s;
                  end
                  RSP_VALID_O <= 1'b1;
                  RD_N_O <= 1'b1;
                  WR_N_O <= 1'b1;
                  MEMRQ_N_O <= 1'b1;
                  IORQ_N_O <= 1'b1;
                  STATUS1_N_O <= 1'b1;
                  DATA_OE_O <= 1'b0;
                  state_reg <= `ST_IDLE;
               end
               `ST_INTAK: begin
                  MCSYNC_N_O <= 1'b1;
                  if (waitrq_n_s) begin
                     INT_VECTOR_O <= data_s;
                     INT_TAKEN_O <= 1'b1;
                     INTAK_N_O <= 1'b1;
                     state_reg <= `ST_IDLE;
                  end
               end
               `ST_REFRESH: begin
                  MCSYNC_N_O <= 1'b1;
                  REFRESH_N_O <= 1'b1;
                  MEMRQ_N_O <= 1'b1;
                  state_reg <= `ST_IDLE;
               end
               `ST_RELEASED: begin
                  if (busrq_n_s) begin
                     BUSAK_N_O <= 1'b1;
                     state_reg <= `ST_IDLE;
                  end
               end
               default: begin
                  state_reg <= `ST_IDLE;
               end
            endcase
         end
      end
   end
endmodule // bus_ctrl

// >>> verif/bus_ctrl_assertions.sv
// Purpose: Port checks for bus_ctrl
// Assumes: One core clock domain
// Notes: Bound from the bench top
`timescale 1ns/1ps
module bus_ctrl_assertions (
   // Clock and reset
   input wire CLOCK_I,
   input wire RST_N_I,
   // Core side
   input wire CMD_READY_O,
   input wire RSP_VALID_O,
   input wire INT_TAKEN_O,
   // Bus side
   input wire [15:0] ADDR_O,
   input wire ADDR_OE_O,
   input wire [7:0] DATA_O,
   input wire DATA_OE_O,
   input wire RD_N_O,
   input wire WR_N_O,
   input wire MEMRQ_N_O,
   input wire IORQ_N_O,
   input wire REFRESH_N_O,
   input wire MCSYNC_N_O,
   input wire STATUS1_N_O,
   input wire CTRL_OE_O,
   input wire INTAK_N_O,
   input wire BUSAK_N_O,
   input wire PBRESET_N_I,
   input wire SYSRESET_N_O
);
   // ----
   // Sequences
   // ----
   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_N_I);
   sequence start_s;
      $fell(MCSYNC_N_O);
   endsequence
   // Sync stages plus two registers
   sequence pb_held_s;
      (!PBRESET_N_I)[*5];
   endsequence
   float_on_ack_a: assert property (!BUSAK_N_O |-> !ADDR_OE_O && !DATA_OE_O && !CTRL_OE_O)
      else $error("bus driven while released");
   data_float_a: assert property (DATA_OE_O |-> RD_N_O && INTAK_N_O)
      else $error("data driven against read");
   io_addr_a: assert property (!IORQ_N_O |-> ADDR_OE_O && MEMRQ_N_O && $stable(ADDR_O))
      else $error("io select without steady address");
   mem_addr_a: assert property (!MEMRQ_N_O && REFRESH_N_O |-> ADDR_OE_O && $stable(ADDR_O))
      else $error("memory select without steady address");
   wr_data_a: assert property (!WR_N_O |-> DATA_OE_O && $stable(DATA_O))
      else $error("write without steady data");
   sync_width_a: assert property (start_s |-> ##[28:36] $rose(MCSYNC_N_O))
      else $error("sync not one tick");
   ready_start_a: assert property (CMD_READY_O |-> !MCSYNC_N_O && BUSAK_N_O)
      else $error("command taken off cycle start");
   fetch_mark_a: assert property (!STATUS1_N_O |-> WR_N_O && IORQ_N_O)
      else $error("fetch mark on non fetch");
   cycle_len_a: assert property (CMD_READY_O |-> ##[88:400] RSP_VALID_O)
      else $error("cycle length wrong");
   intak_done_a: assert property ($fell(INTAK_N_O) |-> ##[20:100] INT_TAKEN_O)
      else $error("acknowledge without vector");
   pb_reset_a: assert property (pb_held_s |-> !SYSRESET_N_O)
      else $error("pushbutton not resetting");
   refresh_a: assert property (!REFRESH_N_O |-> RD_N_O && WR_N_O)
      else $error("refresh during transfer");
endmodule // bus_ctrl_assertions

// >>> verif/card_model.sv
// Purpose: Memory, I/O and interrupter card
// Assumes: Low address byte selects
// Notes: Optional wait stretch
`timescale 1ns/1ps
module card_model #(
   parameter [7:0] VECTOR = 8'h5a
) (
   // Strobes
   input wire rd_n_i,
   input wire wr_n_i,
   input wire memrq_n_i,
   input wire iorq_n_i,
   input wire intak_n_i,
   input wire sysreset_n_i,
   // Bus
   input wire [7:0] addr_i,
   input wire [7:0] dout_i,
   input wire data_oe_i,
   input wire slow_i,
   output wire [7:0] data_o,
   output wire waitrq_n_o
);
   reg [7:0] mem [0:255];
   reg [7:0] last = 8'h00;
   reg wait_n = 1'b1;
   wire memex_n = 1'b0;
   // Single card: chain in tied high, blocked while acknowledging
   wire pc_in = 1'b1;
   wire pc_out = !intak_n_i ? 1'b0 : pc_in;
   wire sel = !rd_n_i && !(memrq_n_i && iorq_n_i);
   wire [7:0] card = !intak_n_i ? VECTOR : mem[addr_i];
   wire card_oe = sel || !intak_n_i;
   // Floating lines must not look held
   assign data_o = data_oe_i ? dout_i : card_oe ? card : ~last;
   assign waitrq_n_o = wait_n;
   initial for (int i = 0; i < 256; i++) mem[i] = 8'(i);
   always @(negedge card_oe) last = card;
   always @(negedge data_oe_i) last = dout_i;
   always @(negedge sysreset_n_i) last = 8'h00;
   always @(negedge wr_n_i) mem[addr_i] = dout_i;
   always @(negedge memrq_n_i or negedge iorq_n_i) begin
      if (slow_i) begin
         wait_n = 1'b0;
         #250 wait_n = 1'b1;
      end
   end
endmodule // card_model

// >>> verif/eight_bit_backplane_bus_bench.sv
// Purpose: Bench for bus_ctrl
// Assumes: Short power-on and refresh counts
// Notes: Card model answers the bus
`timescale 1ns/1ps
`include "bus_ctrl_defs.vh"
module eight_bit_backplane_bus_bench;
   localparam [7:0] VEC = 8'h5a;
   logic clk = 0, rst_n = 0, v = 0, fetch = 0, ien = 0, bclk_n = 1, busrq_n = 1;
   logic intrq_n = 1, nmi_n = 1, pb_n = 1, slow = 0, io;
   logic [1:0] kind = 0;
   logic [15:0] addr = 0, ad;
   logic [7:0] wd = 0, d;
   logic [7:0] shadow [0:255];
   wire ready, rsp, nmit, intt, aoe, doe, rd_n, wr_n, memrq_n, iorq_n, intak_n;
   wire busak_n, sysr_n, waitrq_n, refr_n;
   wire [7:0] rdat, vec, dout, din;
   wire [15:0] a;
   wire [7:0] ev = {nmit | intt, nmit, intt, busak_n, ~busak_n, sysr_n, rsp, ready};
   int miscompares = 0, tests_run = 0, seed = 32'hee59, n, i, nint = 0, nrdy = 0, r0;
   int nref = 0;
   // Gap spans several ticks so commands are not starved by refresh
   bus_ctrl #(.POR_COUNT(4), .REFRESH_GAP(16'h0100)) dut (
      .CLOCK_I(clk), .RST_N_I(rst_n), .CMD_VALID_I(v), .CMD_KIND_I(kind),
      .CMD_FETCH_I(fetch), .CMD_ADDR_I(addr), .CMD_WDATA_I(wd), .INT_ENABLE_I(ien),
      .CMD_READY_O(ready), .RSP_VALID_O(rsp), .RSP_RDATA_O(rdat), .NMI_TAKEN_O(nmit),
      .INT_TAKEN_O(intt), .INT_VECTOR_O(vec), .BUS_CLOCK_N_I(bclk_n), .ADDR_O(a),
      .ADDR_OE_O(aoe), .DATA_I(din), .DATA_O(dout), .DATA_OE_O(doe), .RD_N_O(rd_n),
      .WR_N_O(wr_n), .MEMRQ_N_O(memrq_n), .IORQ_N_O(iorq_n), .REFRESH_N_O(refr_n),
      .MCSYNC_N_O(), .STATUS1_N_O(), .CTRL_OE_O(), .INTAK_N_O(intak_n),
      .BUSRQ_N_I(busrq_n), .BUSAK_N_O(busak_n), .WAITRQ_N_I(waitrq_n),
      .INTRQ_N_I(intrq_n), .NMIRQ_N_I(nmi_n), .PBRESET_N_I(pb_n), .SYSRESET_N_O(sysr_n));
   card_model #(.VECTOR(VEC)) card (.rd_n_i(rd_n), .wr_n_i(wr_n), .memrq_n_i(memrq_n),
      .iorq_n_i(iorq_n), .intak_n_i(intak_n), .sysreset_n_i(sysr_n), .addr_i(a[7:0]),
      .dout_i(dout),
      .data_oe_i(doe), .slow_i(slow), .data_o(din), .waitrq_n_o(waitrq_n));
   // ----
   // Clocks and monitors
   // ----
   initial forever #2 clk = ~clk;
   // Bus clock phase unrelated to the core clock
   initial begin
      #1.3;
      forever #62.5 bclk_n = ~bclk_n;
   end
   always @(posedge clk) begin
      if (intt === 1'b1) nint++;
      if (ready === 1'b1) nrdy++;
      if (refr_n === 1'b0) nref++;
   end
   // ----
   // Tasks
   // ----
   task chk(logic [15:0] s, logic [15:0] e, string nm);
      tests_run++;
      if (s !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, s);
      end
   endtask
   task finish_test;
      $display("Checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task wfor(int b);
      for (n = 0; ev[b] !== 1'b1; n++) begin
         if (n > 4000) begin
            miscompares++;
            finish_test;
         end
         @(posedge clk) #1;
      end
   endtask
   // Request held until taken, released after
   task cyc(logic [1:0] k, logic [15:0] x, logic [7:0] y);
      @(posedge clk) #1;
      {v, kind, addr, wd} = {1'b1, k, x, y};
      fetch = (k == `KIND_MEM_RD) && y[0];
      wfor(0);
      v = 0;
      wfor(1);
   endtask
   // ----
   // Scenarios
   // ----
   initial begin
      repeat (2) @(posedge clk);
      #1 rst_n = 1;
      wfor(2);
      chk(16'(n inside {[5:7]}), 1, "power on length");
      pb_n = 0;
      repeat (8) @(posedge clk);
      #1 chk(sysr_n, 0, "pushbutton reset");
      pb_n = 1;
      wfor(2);
      $display("reset test done");
      for (i = 0; i < 10; i++) begin
         ad = (i < 2) ? {16{i[0]}} : 16'($random(seed));
         d = (i < 2) ? {8{~i[0]}} : 8'($random(seed));
         io = $random(seed);
         slow = $random(seed);
         cyc(io ? `KIND_IO_WR : `KIND_MEM_WR, ad, d);
         shadow[ad[7:0]] = d;
         cyc(io ? `KIND_IO_RD : `KIND_MEM_RD, ad, d);
         chk(rdat, shadow[ad[7:0]], "read data");
      end
      $display("transfer test done");
      busrq_n = 0;
      wfor(3);
      chk(aoe, 0, "address float");
      r0 = nrdy;
      {v, kind, addr} = {1'b1, `KIND_MEM_RD, 16'h0000};
      repeat (300) @(posedge clk);
      #1 chk(16'(nrdy - r0), 0, "held while released");
      busrq_n = 1;
      wfor(0);
      v = 0;
      wfor(1);
      chk(rdat, shadow[0], "read after release");
      $display("handover test done");
      intrq_n = 0;
      cyc(`KIND_MEM_RD, 16'h00ff, 8'h00);
      chk(16'(nint), 0, "masked request");
      ien = 1;
      wfor(5);
      intrq_n = 1;
      chk(vec, VEC, "vector");
      repeat (100) @(posedge clk);
      #1 {intrq_n, nmi_n} = 2'b00;
      wfor(7);
      chk(nmit, 1, "nmi first");
      nmi_n = 1;
      wfor(5);
      intrq_n = 1;
      $display("interrupt test done");
      chk(16'(nref > 0), 1, "refresh seen");
      finish_test;
   end
endmodule // eight_bit_backplane_bus_bench
bind bus_ctrl bus_ctrl_assertions chk (.*);
